// File: shared/pls_pkg.sv
// Notes on behaviour
// - Keyboard found at power-up: console output goes to the graphics monitor.
// - No keyboard found at power-up: console text goes to the serial port.
// - Serial console runs 9600 baud, 8 data, no parity, 1 stop, Xon/Xoff, full duplex.
// - Among graphics controllers the lowest slot wins; base video sits at slot 3.
// - A stored console setting may force serial or force graphics.
// - Right after start the LED gives exactly 2 short flashes.
// - Then the LED stays dark during initialisation, about 30 seconds.
// - Base memory fault during initialisation gives endless long flashes.
// - Console pattern: 2 flashes for graphics, 3 flashes for serial.
// - Console pattern opens with one long flash, then one or two short ones.
// - After the pattern the LED stays dark again while self-test runs.
// - Self-test passed: LED turns on and stays on.
// - Unisolated self-test failure: LED stays off beyond the dark period.
package pls_pkg;

  localparam longint unsigned CLK_HZ = 64'h0000_0000_05F5_E100;
  localparam longint unsigned CLK_KHZ = CLK_HZ / 64'h0000_0000_0000_03E8;

  // Flash timing in milliseconds, dark period in seconds
  localparam longint unsigned SHORT_ON_MS = 64'h0000_0000_0000_00FA;
  localparam longint unsigned LONG_ON_MS = 64'h0000_0000_0000_03E8;
  localparam longint unsigned FLASH_GAP_MS = 64'h0000_0000_0000_00FA;
  localparam longint unsigned DARK_S = 64'h0000_0000_0000_001E;

  localparam longint unsigned SHORT_ON_CYC = SHORT_ON_MS * CLK_KHZ;
  localparam longint unsigned LONG_ON_CYC = LONG_ON_MS * CLK_KHZ;
  localparam longint unsigned FLASH_GAP_CYC = FLASH_GAP_MS * CLK_KHZ;
  localparam longint unsigned DARK_CYC = DARK_S * CLK_HZ;

  // Flash counts
  localparam logic [1:0] PWR_FLASHES = 2'h2;
  localparam logic [1:0] SEL_FLASHES_GFX = 2'h2;
  localparam logic [1:0] SEL_FLASHES_SER = 2'h3;

  // Slots
  localparam int unsigned NUM_SLOTS = 4;
  localparam logic [1:0] BASE_VIDEO_SLOT = 2'h3;

  // Serial console line settings
  localparam longint unsigned SER_BAUD = 64'h0000_0000_0000_2580;
  localparam logic [15:0] SER_BAUD_DIV = 16'(CLK_HZ / SER_BAUD);
  localparam logic [3:0] SER_DATA_BITS = 4'h8;
  localparam logic [1:0] SER_STOP_BITS = 2'h1;
  localparam logic SER_PARITY_EN = 1'h0;
  localparam logic SER_XONXOFF_EN = 1'h1;
  localparam logic SER_FULL_DUPLEX = 1'h1;

  // Sequencer states, Gray along the normal path
  typedef enum logic [2:0] {
    ST_PWR = 3'h0,
    ST_DARK1 = 3'h1,
    ST_SEL = 3'h3,
    ST_DARK2 = 3'h2,
    ST_ON = 3'h6,
    ST_FAILED = 3'h7,
    ST_FAULT = 3'h5
  } pls_st_t;

endpackage : pls_pkg

// File: hw/pls_core.sv
`timescale 1ns/1ps
module pls_core import pls_pkg::*; #(
  parameter int unsigned SLOTS = NUM_SLOTS,
  parameter int unsigned SLOT_W = 2,
  parameter int unsigned SHORT_ON = 32'(SHORT_ON_CYC),
  parameter int unsigned LONG_ON = 32'(LONG_ON_CYC),
  parameter int unsigned FLASH_GAP = 32'(FLASH_GAP_CYC),
  parameter int unsigned DARK_TIME = 32'(DARK_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins from the probes
  input wire logic kbd_present,
  input wire logic [SLOTS-1:0] gfx_present,
  // Stored console setting
  input wire logic cfg_ovr_en,
  input wire logic cfg_ovr_serial,
  // Firmware progress events
  input wire logic mem_fault,
  input wire logic init_done,
  input wire logic selftest_pass,
  input wire logic selftest_fail,
  // Front LED
  output logic led,
  // Console choice
  output logic con_valid,
  output logic con_serial,
  output logic [SLOT_W-1:0] con_slot,
  // Status
  output logic dark_overrun,
  output pls_st_t seq_state,
  // Serial line setup
  output logic [15:0] ser_baud_div,
  output logic [3:0] ser_data_bits,
  output logic [1:0] ser_stop_bits,
  output logic ser_parity_en,
  output logic ser_xonxoff_en,
  output logic ser_full_duplex
);

  pls_st_t st_ff;
  logic led_ff;
  logic long_ff;
  logic [1:0] left_ff;
  logic [31:0] tmr_ff;
  logic kbd_m_ff;
  logic kbd_s_ff;
  logic [SLOTS-1:0] gfx_m_ff;
  logic [SLOTS-1:0] gfx_s_ff;
  logic con_valid_ff;
  logic con_serial_ff;
  logic [SLOT_W-1:0] con_slot_ff;
  logic [31:0] dark_tmr_ff;
  logic dark_over_ff;
  logic [15:0] baud_ff;
  logic nxt_serial;
  logic [SLOT_W-1:0] nxt_slot;
  logic in_dark;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kbd_m_ff <= 1'h0;
      kbd_s_ff <= 1'h0;
      gfx_m_ff <= '0;
      gfx_s_ff <= '0;
    end else begin
      kbd_m_ff <= kbd_present;
      kbd_s_ff <= kbd_m_ff;
      gfx_m_ff <= gfx_present;
      gfx_s_ff <= gfx_m_ff;
    end
  end

  // Console decision
  always_comb begin
    nxt_slot = BASE_VIDEO_SLOT[SLOT_W-1:0];
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (gfx_s_ff[i]) begin
        nxt_slot = SLOT_W'(i);
      end
    end
    if (cfg_ovr_en) begin
      nxt_serial = cfg_ovr_serial;
    end else begin
      nxt_serial = !kbd_s_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      con_valid_ff <= 1'h0;
      con_serial_ff <= 1'h0;
      con_slot_ff <= '0;
    end else if (st_ff == ST_DARK1 && init_done && !mem_fault) begin
      con_valid_ff <= 1'h1;
      con_serial_ff <= nxt_serial;
      con_slot_ff <= nxt_slot;
    end
  end

  // LED sequencer and flash engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= ST_PWR;
      led_ff <= 1'h1;
      long_ff <= 1'h0;
      left_ff <= PWR_FLASHES;
      tmr_ff <= SHORT_ON - 32'h0000_0001;
    end else begin
      unique case (st_ff)
        ST_PWR, ST_SEL, ST_FAULT: begin
          if ((st_ff == ST_PWR) && mem_fault) begin
            st_ff <= ST_FAULT;
            led_ff <= 1'h1;
            long_ff <= 1'h1;
            tmr_ff <= LONG_ON - 32'h0000_0001;
          end else if (tmr_ff != 32'h0000_0000) begin
            tmr_ff <= tmr_ff - 32'h0000_0001;
          end else if (led_ff) begin
            led_ff <= 1'h0;
            tmr_ff <= FLASH_GAP - 32'h0000_0001;
            if (st_ff != ST_FAULT) begin
              left_ff <= left_ff - 2'h1;
              long_ff <= 1'h0;
            end
          end else if (st_ff != ST_FAULT && left_ff == 2'h0) begin
            st_ff <= (st_ff == ST_PWR) ? ST_DARK1 : ST_DARK2;
          end else begin
            led_ff <= 1'h1;
            tmr_ff <= (long_ff ? LONG_ON : SHORT_ON) - 32'h0000_0001;
          end
        end
        ST_DARK1: begin
          led_ff <= 1'h0;
          if (mem_fault) begin
            st_ff <= ST_FAULT;
            led_ff <= 1'h1;
            long_ff <= 1'h1;
            tmr_ff <= LONG_ON - 32'h0000_0001;
          end else if (init_done) begin
            st_ff <= ST_SEL;
            led_ff <= 1'h1;
            long_ff <= 1'h1;
            left_ff <= nxt_serial ? SEL_FLASHES_SER : SEL_FLASHES_GFX;
            tmr_ff <= LONG_ON - 32'h0000_0001;
          end
        end
        ST_DARK2: begin
          led_ff <= 1'h0;
          if (selftest_fail) begin
            st_ff <= ST_FAILED;
          end else if (selftest_pass) begin
            st_ff <= ST_ON;
            led_ff <= 1'h1;
          end
        end
        ST_ON: begin
          led_ff <= 1'h1;
        end
        ST_FAILED: begin
          led_ff <= 1'h0;
        end
        default: begin
          st_ff <= ST_FAILED;
          led_ff <= 1'h0;
        end
      endcase
    end
  end

  // Dark period watch
  assign in_dark = (st_ff == ST_DARK1) || (st_ff == ST_DARK2) || (st_ff == ST_FAILED);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dark_tmr_ff <= 32'h0000_0000;
      dark_over_ff <= 1'h0;
    end else if (!in_dark) begin
      dark_tmr_ff <= 32'h0000_0000;
      dark_over_ff <= 1'h0;
    end else if (dark_tmr_ff >= DARK_TIME - 32'h0000_0001) begin
      dark_over_ff <= 1'h1;
    end else begin
      dark_tmr_ff <= dark_tmr_ff + 32'h0000_0001;
    end
  end

  // Serial line setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      baud_ff <= SER_BAUD_DIV;
    end else begin
      baud_ff <= SER_BAUD_DIV;
    end
  end

  assign led = led_ff;
  assign con_valid = con_valid_ff;
  assign con_serial = con_serial_ff;
  assign con_slot = con_slot_ff;
  assign dark_overrun = dark_over_ff;
  assign seq_state = st_ff;
  assign ser_baud_div = baud_ff;
  assign ser_data_bits = SER_DATA_BITS;
  assign ser_stop_bits = SER_STOP_BITS;
  assign ser_parity_en = SER_PARITY_EN;
  assign ser_xonxoff_en = SER_XONXOFF_EN;
  assign ser_full_duplex = SER_FULL_DUPLEX;

  // Flash counter for checks
  pls_st_t prev_st_ff;
  logic led_prev_ff;
  logic [2:0] rise_cnt_ff;
  logic rise;

  assign rise = led_ff && !led_prev_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_st_ff <= ST_PWR;
      led_prev_ff <= 1'h0;
      rise_cnt_ff <= 3'h0;
    end else begin
      prev_st_ff <= st_ff;
      led_prev_ff <= led_ff;
      if (st_ff != prev_st_ff) begin
        rise_cnt_ff <= {2'h0, rise};
      end else if (rise && rise_cnt_ff != 3'h7) begin
        rise_cnt_ff <= rise_cnt_ff + 3'h1;
      end
    end
  end

  AST_PWR_TWO_FLASHES: assert property (@(posedge clk) disable iff (!rst_n)
    (prev_st_ff == ST_PWR && st_ff == ST_DARK1) |-> ($past(rise_cnt_ff) == 3'h2))
    else $error("power-on pattern did not give two flashes");

  AST_DARK1_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_DARK1 && $past(st_ff) == ST_DARK1) |-> !led)
    else $error("LED lit during first dark period");

  AST_MEM_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_fault && (st_ff == ST_PWR || st_ff == ST_DARK1)) |=> (st_ff == ST_FAULT && led)
    ##1 (st_ff == ST_FAULT))
    else $error("memory fault did not start long flashes");

  AST_SEL_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    (prev_st_ff == ST_SEL && st_ff == ST_DARK2) |->
    ($past(rise_cnt_ff) == (con_serial_ff ? 3'h3 : 3'h2)))
    else $error("console pattern flash count wrong");

  AST_SEL_LONG_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_SEL && prev_st_ff == ST_DARK1) |-> (long_ff && led && tmr_ff == LONG_ON - 1))
    else $error("console pattern did not open with a long flash");

  AST_CONSOLE_PICK: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_SEL && prev_st_ff == ST_DARK1) |->
    (con_serial_ff == ($past(cfg_ovr_en) ? $past(cfg_ovr_serial) : !$past(kbd_s_ff))))
    else $error("console choice does not match probe or setting");

  AST_LOW_SLOT: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_SEL && prev_st_ff == ST_DARK1 && $past(gfx_s_ff[0])) |-> (con_slot_ff == 0))
    else $error("slot 0 controller not chosen");

  AST_DARK2_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_DARK2 && $past(st_ff) == ST_DARK2) |-> !led)
    else $error("LED lit during self-test period");

  AST_PASS_ON: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_DARK2 && selftest_pass && !selftest_fail) |=> (led && st_ff == ST_ON) [*3])
    else $error("LED not steady after self-test pass");

  AST_FAIL_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_DARK2 && selftest_fail) |=> ##1 (!led && st_ff == ST_FAILED) [*3])
    else $error("LED not off after self-test failure");

  AST_FAULT_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_FAULT) |=> (st_ff == ST_FAULT))
    else $error("fault pattern left without reset");

  AST_FAULT_LONG: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_FAULT && led_ff && !led_prev_ff) |-> (tmr_ff == LONG_ON - 1))
    else $error("fault flash is not a long flash");

  AST_ON_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_ON) |=> (st_ff == ST_ON && led))
    else $error("LED left the steady on state");

  AST_FAILED_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == ST_FAILED) |=> (st_ff == ST_FAILED && !led))
    else $error("LED left the failed dark state");

  AST_OVERRUN_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (in_dark && dark_tmr_ff == DARK_TIME - 1) |=> dark_overrun)
    else $error("dark overrun not raised after full dark time");

  AST_OVERRUN_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    (!in_dark) |=> !dark_overrun)
    else $error("dark overrun raised outside a dark phase");

  AST_CON_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    con_valid_ff |=> (con_valid_ff && $stable(con_serial_ff) && $stable(con_slot_ff)))
    else $error("console choice changed after it was made");

endmodule : pls_core

// File: verification/pls_led_watch.sv
`timescale 1ns/1ps
module pls_led_watch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Front LED
  input wire logic led,
  // Finished flash
  output logic flash_done,
  output logic [31:0] flash_len
);
  logic [31:0] on_cnt_ff;

  // Lit cycles of the current flash
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on_cnt_ff <= 32'h0000_0000;
    end else if (led) begin
      on_cnt_ff <= on_cnt_ff + 32'h0000_0001;
    end else begin
      on_cnt_ff <= 32'h0000_0000;
    end
  end

  // Reported when the lamp goes dark, never across a reset
  always_ff @(posedge clk) begin
    flash_done <= rst_n && !led && (on_cnt_ff != 32'h0000_0000);
    flash_len <= on_cnt_ff;
  end
endmodule : pls_led_watch

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import pls_pkg::*;
  localparam int unsigned SH = 5;
  localparam int unsigned LG = 12;
  localparam int unsigned DK = 50;
  logic clk, rst_n, kbd_present, cfg_ovr_en, cfg_ovr_serial, mem_fault, init_done;
  logic selftest_pass, selftest_fail, led, con_valid, con_serial, dark_overrun;
  logic ser_parity_en, ser_xonxoff_en, ser_full_duplex, flash_done, exp_ser;
  logic [3:0] gfx_present, ser_data_bits;
  logic [1:0] con_slot, ser_stop_bits, exp_slot;
  logic [15:0] ser_baud_div;
  logic [31:0] flash_len, exp_v, rnd;
  logic [31:0] exp_q[$];
  pls_st_t seq_state;
  int fails, checks_done;

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

  pls_core #(.SHORT_ON(SH), .LONG_ON(LG), .FLASH_GAP(4), .DARK_TIME(DK)) pls_core_inst (
    .clk(clk), .rst_n(rst_n), .kbd_present(kbd_present), .gfx_present(gfx_present),
    .cfg_ovr_en(cfg_ovr_en), .cfg_ovr_serial(cfg_ovr_serial), .mem_fault(mem_fault),
    .init_done(init_done), .selftest_pass(selftest_pass), .selftest_fail(selftest_fail),
    .led(led), .con_valid(con_valid), .con_serial(con_serial), .con_slot(con_slot),
    .dark_overrun(dark_overrun), .seq_state(seq_state), .ser_baud_div(ser_baud_div),
    .ser_data_bits(ser_data_bits), .ser_stop_bits(ser_stop_bits),
    .ser_parity_en(ser_parity_en), .ser_xonxoff_en(ser_xonxoff_en),
    .ser_full_duplex(ser_full_duplex));

  pls_led_watch pls_led_watch_inst (.clk(clk), .rst_n(rst_n), .led(led),
    .flash_done(flash_done), .flash_len(flash_len));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic restart();
    rst_n = 1'b0;
    tick(4);
    rst_n = 1'b1;
    exp_q.push_back(SH);
    exp_q.push_back(SH);
  endtask : restart

  // Waits for a state with every noted flash seen
  task automatic wait_for(input pls_st_t s);
    int i;
    i = 0;
    while ((seq_state !== s || exp_q.size() != 0) && i < 2000) begin
      tick(1);
      i++;
    end
    if (i == 2000) begin
      fails++;
      final_report();
    end
  endtask : wait_for

  always @(posedge clk) begin
    if (flash_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("unexpected flash expected none seen %0d", flash_len);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK("flash_len", exp_v, flash_len)
      end
    end
  end

  initial begin
    {kbd_present, cfg_ovr_en, cfg_ovr_serial, mem_fault, init_done} = 5'h00;
    {selftest_pass, selftest_fail, rst_n} = 3'h0;
    gfx_present = 4'h0;
    rnd = 32'h0000_42A3;
    for (int r = 0; r < 6; r++) begin
      rnd = xs(rnd);
      kbd_present = r[0] ^ r[1];
      gfx_present = (r == 0) ? 4'h0 : rnd[3:0];
      cfg_ovr_en = (r >= 4);
      cfg_ovr_serial = r[0];
      restart();
      wait_for(ST_DARK1);
      tick(DK + 2);
      `CHK("dark1_led", 1'b0, led)
      `CHK("dark_overrun", 1'b1, dark_overrun)
      exp_ser = cfg_ovr_en ? cfg_ovr_serial : !kbd_present;
      exp_slot = 2'h3;
      for (int i = 3; i >= 0; i--) if (gfx_present[i]) exp_slot = 2'(i);
      exp_q.push_back(LG);
      exp_q.push_back(SH);
      if (exp_ser) exp_q.push_back(SH);
      init_done = 1'b1;
      tick(1);
      init_done = 1'b0;
      `CHK("con_valid", 1'b1, con_valid)
      `CHK("con_serial", exp_ser, con_serial)
      `CHK("con_slot", exp_slot, con_slot)
      wait_for(ST_DARK2);
      `CHK("dark2_led", 1'b0, led)
      if (r[1]) selftest_fail = 1'b1;
      else selftest_pass = 1'b1;
      tick(1);
      {selftest_pass, selftest_fail} = 2'h0;
      tick(DK + 2);
      `CHK("end_led", !r[1], led)
      `CHK("end_state", r[1] ? ST_FAILED : ST_ON, seq_state)
    end
    `CHK("ser_baud", 16'h28B0, ser_baud_div)
    `CHK("ser_data_bits", 4'h8, ser_data_bits)
    `CHK("ser_stop_bits", 2'h1, ser_stop_bits)
    `CHK("ser_line_mode", 3'h3, {ser_parity_en, ser_xonxoff_en, ser_full_duplex})
    restart();
    wait_for(ST_DARK1);
    repeat (3) exp_q.push_back(LG);
    mem_fault = 1'b1;
    tick(1);
    mem_fault = 1'b0;
    wait_for(ST_FAULT);
    final_report();
  end
endmodule : tb
